// ==== ckg_gate_top.sv ====
// Purpose: output enable and power state gating of six clock outputs
// Assumes: pclk is the output clock source; pins are asynchronous
// Notes: output clock is pclk divided by two
//
// Functional notes
// - one software enable bit per output
// - one active low enable pin per output
// - software enables active high, reset enabled
// - disabled output drives both legs low
// - output runs only if bit 1, pin 0
// - power input low stops all, PLL off
// - bit cleared stops output, feedback keeps running
// - outputs locked within settle time
// - enable resumes glitch free, 4 to 12 periods
// - disable: four clocks more, done within 12
// - two low samples force low at fall
// - first high latches straps, then power down
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ckg_gate_top
  import ckg_pkg::*;
#(
  parameter int SETTLE_CYC = CKG_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] out_enable_n,
  input wire logic power_good_or_down,
  input wire logic [3:0] strap_in,
  output logic [5:0] diff_clock_out_p,
  output logic [5:0] diff_clock_out_n,
  output logic feedback_clock_out_p,
  output logic feedback_clock_out_n,
  output logic pll_enable
);
  // synchronised pins
  logic [5:0] oe_n_s; // enable pins, active low
  logic pgd_s; // power input after sync
  // apb slave state
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [5:0] sw_en_ff, nxt_sw_en; // software enables
  // power state
  logic pgd_prev_ff, nxt_pgd_prev; // last synced power sample
  logic first_ff, nxt_first; // power input has been high once
  logic [3:0] strap_ff, nxt_strap; // latched straps
  logic force_ff, nxt_force; // all outputs held low
  logic pll_ff, nxt_pll; // pll running
  logic [15:0] lock_cnt_ff, nxt_lock_cnt; // settle counter
  logic locked_ff, nxt_locked; // pll settled
  // output clock and pins
  logic phase_ff, nxt_phase; // output clock level
  logic [5:0] dp_ff, nxt_dp;
  logic [5:0] dn_ff, nxt_dn;
  logic fbp_ff, nxt_fbp;
  logic fbn_ff, nxt_fbn;
  logic [5:0] want; // per output run request
  logic [5:0] active; // per output gate state
  logic pd_seen; // low on two consecutive edges
  logic tick; // output clock falls at next edge

  // pins are asynchronous; enable pins reset to disabled
  ckg_sync #(.W(6), .RST_VAL(6'h3f)) u_oe_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d_async(out_enable_n),
    .q_sync(oe_n_s)
  );

  // power input resets low so nothing runs until it is seen high
  ckg_sync #(.W(1), .RST_VAL(1'b0)) u_pgd_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d_async(power_good_or_down),
    .q_sync(pgd_s)
  );

  // read mux used by the apb read decode
  function automatic logic [31:0] rd_word(input logic [7:0] a,
      input logic [5:0] en, input logic [5:0] act, input logic [3:0] st,
      input logic [3:0] pw);
    logic [31:0] w;
    w = 32'h0;
    if (a == CKG_CTRL_OFS) begin
      w[5:0] = en;
    end else if (a == CKG_STAT_OFS) begin
      w[5:0] = act;
      w[CKG_ST_PLL_ON] = pw[0];
      w[CKG_ST_LOCKED] = pw[1];
      w[CKG_ST_FORCE] = pw[2];
      w[CKG_ST_FIRST] = pw[3];
    end else if (a == CKG_STRAP_OFS) begin
      w[3:0] = st;
    end
    return w;
  endfunction : rd_word

  // address is mapped when it hits one of three words
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == CKG_CTRL_OFS) || (a == CKG_STAT_OFS) ||
      (a == CKG_STRAP_OFS);
  endfunction : is_mapped

  // apb: answer in the first access cycle, no wait states
  always_comb begin
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !is_mapped(paddr);
    nxt_prdata = prdata_ff;
    nxt_sw_en = sw_en_ff;
    if (psel && !penable) begin
      // read data captured at setup so it comes from a flop
      nxt_prdata = pwrite ? 32'h0 : rd_word(paddr, sw_en_ff, active,
        strap_ff, {first_ff, force_ff, locked_ff, pll_ff});
    end
    if (psel && penable && pready_ff && pwrite &&
        paddr == CKG_CTRL_OFS) begin
      nxt_sw_en = pwdata[5:0];
    end
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      sw_en_ff <= CKG_SW_EN_RST;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      sw_en_ff <= nxt_sw_en;
    end
  end

  assign pd_seen = !pgd_s && !pgd_prev_ff;
  assign tick = phase_ff;

  // power sequencing: strap latch, power down, pll and settle
  always_comb begin
    nxt_pgd_prev = pgd_s;
    nxt_first = first_ff;
    nxt_strap = strap_ff;
    nxt_force = force_ff;
    nxt_lock_cnt = lock_cnt_ff;
    nxt_locked = locked_ff;
    if (pgd_s && !first_ff) begin
      // first high level captures straps; later it is power down
      nxt_first = 1'b1;
      nxt_strap = strap_in;
    end
    if (pgd_s) begin
      nxt_force = 1'b0;
    end else if (pd_seen && tick) begin
      // wait for the falling edge so the last high is whole
      nxt_force = 1'b1;
    end
    // pll stops at the same edge that forces the outputs low
    nxt_pll = !nxt_force;
    if (!pll_ff) begin
      nxt_lock_cnt = 16'h0;
      nxt_locked = 1'b0;
    end else if (!locked_ff) begin
      if (lock_cnt_ff == 16'(SETTLE_CYC - 1)) begin
        nxt_locked = 1'b1;
      end else begin
        nxt_lock_cnt = lock_cnt_ff + 16'h1;
      end
    end
  end

  // power state registers; held forced until power seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgd_prev_ff <= 1'b0;
      first_ff <= 1'b0;
      strap_ff <= 4'h0;
      force_ff <= 1'b1;
      pll_ff <= 1'b0;
      lock_cnt_ff <= 16'h0;
      locked_ff <= 1'b0;
    end else begin
      pgd_prev_ff <= nxt_pgd_prev;
      first_ff <= nxt_first;
      strap_ff <= nxt_strap;
      force_ff <= nxt_force;
      pll_ff <= nxt_pll;
      lock_cnt_ff <= nxt_lock_cnt;
      locked_ff <= nxt_locked;
    end
  end

  // run request: bit set, pin low, locked, not powered down
  always_comb begin
    want = sw_en_ff & ~oe_n_s;
    if (!locked_ff || force_ff) begin
      want = 6'h0;
    end
  end

  // one glitch free gate per output
  for (genvar g = 0; g < CKG_NOUT; g++) begin : g_gate
    ckg_out_gate u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .want(want[g]),
      .tick(tick),
      .active(active[g])
    );
  end

  // output pins; a stopped leg pair sits low/low
  always_comb begin
    nxt_phase = !phase_ff;
    nxt_dp = {6{nxt_phase}} & active;
    nxt_dn = {6{!nxt_phase}} & active;
    nxt_fbp = nxt_phase && locked_ff;
    nxt_fbn = !nxt_phase && locked_ff;
    if (nxt_force) begin
      nxt_dp = 6'h0;
      nxt_dn = 6'h0;
      nxt_fbp = 1'b0;
      nxt_fbn = 1'b0;
    end
  end

  // output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
      dp_ff <= 6'h0;
      dn_ff <= 6'h0;
      fbp_ff <= 1'b0;
      fbn_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      dp_ff <= nxt_dp;
      dn_ff <= nxt_dn;
      fbp_ff <= nxt_fbp;
      fbn_ff <= nxt_fbn;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign diff_clock_out_p = dp_ff;
  assign diff_clock_out_n = dn_ff;
  assign feedback_clock_out_p = fbp_ff;
  assign feedback_clock_out_n = fbn_ff;
  assign pll_enable = pll_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_force_holds_low: assert property (force_ff |->
    (dp_ff == 6'h0 && dn_ff == 6'h0 && !fbp_ff && !fbn_ff && !pll_ff))
    else $error("outputs or pll active while forced");
  a_legs_never_both: assert property ((dp_ff & dn_ff) == 6'h0)
    else $error("both legs of an output high");
  a_stopped_is_low: assert property ($past(!active[0]) &&
    !active[0] |-> !dp_ff[0] && !dn_ff[0])
    else $error("stopped output not low on both legs");
  a_ctrl_write_lands: assert property (psel && penable && pready_ff &&
    pwrite && paddr == CKG_CTRL_OFS |=> sw_en_ff == $past(pwdata[5:0]))
    else $error("enable write not stored");
  a_want_gating: assert property ((sw_en_ff[0] == 1'b0 ||
    oe_n_s[0]) |-> !want[0])
    else $error("output requested without bit and pin");
  a_pd_force_edge: assert property (pd_seen && tick && !pgd_s |=>
    force_ff && dp_ff == 6'h0)
    else $error("power down not forced at falling edge");
  a_enable_latency: assert property (!active[0] ##1 want[0] [*8]
    |-> ##[0:16] active[0])
    else $error("enable latency too long");
  a_disable_clocks: assert property ($fell(want[0]) && active[0]
    |-> active[0] [*8])
    else $error("fewer than four clocks after disable");
  a_first_strap: assert property (pgd_s && !first_ff |=>
    first_ff && strap_ff == $past(strap_in))
    else $error("straps not latched on first power good");
  a_fb_runs_bit_off: assert property (locked_ff ##1 locked_ff &&
    !force_ff && !sw_en_ff[0] ##1 locked_ff && !force_ff
    |-> fbp_ff != $past(fbp_ff))
    else $error("feedback stopped while only a bit cleared");

  c_out_enabled: cover property ($rose(active[0]));
  c_out_disabled: cover property ($fell(active[0]));
  c_power_down: cover property ($rose(force_ff) && first_ff);
  c_bad_addr: cover property (pslverr_ff);
endmodule : ckg_gate_top

// ==== ckg_pkg.sv ====
// Purpose: shared constants for the clock output enable gating block
// Assumes: pclk at 10 MHz stands in for the output clock domain
// Notes: apb word offsets are byte addresses
package ckg_pkg;
  // register byte offsets
  localparam logic [7:0] CKG_CTRL_OFS = 8'h00;
  localparam logic [7:0] CKG_STAT_OFS = 8'h04;
  localparam logic [7:0] CKG_STRAP_OFS = 8'h08;
  // number of differential outputs
  localparam int CKG_NOUT = 6;
  // software enables come out of reset all enabled
  localparam logic [5:0] CKG_SW_EN_RST = 6'h3f;
  // status field positions
  localparam int CKG_ST_PLL_ON = 8;
  localparam int CKG_ST_LOCKED = 9;
  localparam int CKG_ST_FORCE = 10;
  localparam int CKG_ST_FIRST = 11;
  // width of latched strap word
  localparam int CKG_STRAP_W = 4;
  // output periods a gate waits before switching state
  localparam logic [3:0] CKG_DWELL_PER = 4'h4;
  // timing: clock period and settle time in ns
  localparam int CKG_PCLK_NS = 100;
  localparam int CKG_SETTLE_NS = 1800000;
  // longest time rounds down to whole cycles
  localparam int CKG_SETTLE_CYC = CKG_SETTLE_NS / CKG_PCLK_NS;
endpackage : ckg_pkg

// ==== ckg_sync.sv ====
// Purpose: two flop synchroniser for asynchronous level inputs
// Assumes: inputs are levels held longer than two clocks
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module ckg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q_sync
);
  logic [W-1:0] meta_ff; // first stage, may go metastable
  logic [W-1:0] sync_ff; // second stage, safe to use
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // next values of both stages
  always_comb begin
    nxt_meta = d_async;
    nxt_sync = meta_ff;
  end

  // register both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_sync = sync_ff;
endmodule : ckg_sync

// ==== ckg_out_gate.sv ====
// Purpose: glitch free start and stop of one output
// Assumes: tick is high in the cycle before the output clock falls
// Notes: state changes only at a falling output edge
`timescale 1ns/1ps
module ckg_out_gate
  import ckg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want,
  input wire logic tick,
  output logic active
);
  logic active_ff; // output currently running
  logic nxt_active;
  logic [3:0] per_ff; // output periods spent waiting
  logic [3:0] nxt_per;

  // dwell a fixed number of periods, then switch at a fall
  always_comb begin
    nxt_active = active_ff;
    nxt_per = per_ff;
    if (want == active_ff) begin
      // request agrees with state, nothing pending
      nxt_per = 4'h0;
    end else if (tick) begin
      if (per_ff == CKG_DWELL_PER) begin
        // four whole periods passed since the request changed, so a
        // disable always lets four full clocks out, whatever the phase
        // switch in the low half so no runt pulse appears
        nxt_active = want;
        nxt_per = 4'h0;
      end else begin
        nxt_per = per_ff + 4'h1;
      end
    end
  end

  // outputs start stopped; the lock wait enables them later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= 1'b0;
      per_ff <= 4'h0;
    end else begin
      active_ff <= nxt_active;
      per_ff <= nxt_per;
    end
  end

  assign active = active_ff;
endmodule : ckg_out_gate

// ==== ckg_pin_model.sv ====
// Purpose: board side model of enable pins, power input and straps
// Assumes: the bench sets request levels by nba at or 1 ns after a rising edge
// Notes: pins follow requests one edge later, as board wiring would
`timescale 1ns/1ps
module ckg_pin_model (
  input wire logic pclk,
  input wire logic [5:0] en_req_n,
  input wire logic pg_req,
  input wire logic [3:0] strap_req,
  output logic [5:0] out_enable_n,
  output logic power_good_or_down,
  output logic [3:0] strap_in
);
  // one edge of board delay; reset covers the first unknown edge
  always @(posedge pclk) begin
    out_enable_n <= en_req_n;
    power_good_or_down <= pg_req;
    strap_in <= strap_req;
  end
endmodule : ckg_pin_model

// ==== ckg_gate_top_tb.sv ====
// Purpose: self checking bench for the output gating block
// Assumes: settle count shortened to 20 cycles
// Notes: output clocks sampled 1 ns after each rising edge
`timescale 1ns/1ps
module ckg_gate_top_tb;
  import ckg_pkg::*;
  localparam int SETTLE = 20; // short relock keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, fb_p, fb_n, pll_en, pg, err;
  logic [5:0] en_n, dp, dn;
  logic [5:0] en_req_n = 6'h00; // pins asserted
  logic pg_req = 1'b0; // power held down at start
  logic [3:0] strap, strap_req = 4'ha;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int edges, first, last;

  always #50 pclk = ~pclk;

  ckg_gate_top #(.SETTLE_CYC(SETTLE)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_enable_n(en_n), .power_good_or_down(pg),
    .strap_in(strap), .diff_clock_out_p(dp), .diff_clock_out_n(dn),
    .feedback_clock_out_p(fb_p), .feedback_clock_out_n(fb_n),
    .pll_enable(pll_en));

  ckg_pin_model board (.pclk(pclk), .en_req_n(en_req_n),
    .pg_req(pg_req), .strap_req(strap_req), .out_enable_n(en_n),
    .power_good_or_down(pg), .strap_in(strap));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // count rising edges of output i (6 is feedback) over n cycles
  task automatic watch(input int i, input int n);
    logic prv, cur;
    // first sample taken after the edge, like the later ones
    #1;
    prv = (i < 6) ? dp[i] : fb_p;
    edges = 0;
    first = 0;
    last = 0;
    for (int c = 1; c <= n; c++) begin
      @(posedge pclk);
      #1;
      cur = (i < 6) ? dp[i] : fb_p;
      if (cur && !prv) begin
        edges++;
        last = c;
        if (first == 0) first = c;
      end
      prv = cur;
    end
  endtask : watch

  task automatic conclude();
    $display("counts: %0d checked, %0d mismatched", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // hang guard; whole run needs about 970 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CKG_CTRL_OFS, 32'h0);
    check(rd, 32'h3f);
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], err}, 32'h1); // unmapped read refused
    check(32'({dp, dn, fb_p, fb_n, pll_en}), 32'h0);
    pg_req <= 1'b1;
    watch(0, SETTLE + 40);
    check(32'(first > 0 && first <= SETTLE + 32), 32'h1);
    check(32'(pll_en), 32'h1);
    apb(1'b1, CKG_STRAP_OFS, 32'h3);
    apb(1'b0, CKG_STRAP_OFS, 32'h0);
    check(rd, 32'ha);
    $display("test power_up done");
    // each output: software stop and start, then pin stop and start
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CKG_CTRL_OFS, 32'h3f ^ (32'h1 << i));
      watch(i, 30);
      check(32'(edges >= 4 && last <= 25), 32'h1);
      check(32'({dp[i], dn[i]}), 32'h0);
      watch(6, 4);
      check(32'(edges > 0), 32'h1);
      apb(1'b0, CKG_STAT_OFS, 32'h0);
      check(32'(rd[5:0]), 32'h3f ^ (32'h1 << i));
      apb(1'b1, CKG_CTRL_OFS, 32'h3f);
      watch(i, 30);
      check(32'(first >= 8 && first <= 25), 32'h1);
      en_req_n <= 6'h1 << i;
      watch(i, 30);
      check(32'(edges >= 4 && last <= 26), 32'h1);
      check(32'({dp[i], dn[i]}), 32'h0);
      en_req_n <= 6'h00;
      watch(i, 30);
      check(32'(first >= 8 && first <= 26), 32'h1);
    end
    $display("test enables done");
    strap_req <= 4'h5;
    pg_req <= 1'b0;
    watch(6, 20);
    check(32'(last <= 10), 32'h1);
    check(32'({dp, dn, fb_p, fb_n, pll_en}), 32'h0);
    pg_req <= 1'b1;
    watch(0, SETTLE + 40);
    check(32'(first > 0 && first <= SETTLE + 32), 32'h1);
    apb(1'b0, CKG_STRAP_OFS, 32'h0);
    check(rd, 32'ha);
    $display("test power_down done");
    conclude();
  end
endmodule : ckg_gate_top_tb
